/* File: hw/clock_source_config_ctrl.sv */
// clock source configuration register and internal/external switch sequencer
`timescale 1ns/1ps
`include "clock_source_config_regs.svh"
module clock_source_config_ctrl
    import clock_source_config_pkg::*;
#(
    parameter int RESUME_LONG_CYCLES = `RESUME_LONG_CYC,
    parameter int SUPPLY_SETTLE_CYCLES = `SUPPLY_SETTLE_CYC,
    parameter int CNT_W = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_brownout_reset,
    input wire logic i_watchdog_reset,
    input wire logic i_low_supply,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    input wire logic i_suspend_req,
    input wire logic i_wake,
    input wire logic i_ext_osc_stable,
    input wire logic i_osc_in_pin,
    input wire logic i_usb_traffic,
    input wire logic i_int_clk_phase,
    output logic o_int_osc_en,
    output logic o_ext_osc_en,
    output logic o_chip_clk_en,
    output logic o_cpu_stall,
    output logic o_fetch_restart,
    output logic [15:0] o_fetch_addr,
    output logic o_low_supply_reset_en,
    output logic o_tune_active,
    output logic [2:0] o_wake_period,
    output logic o_osc_out_pin,
    output logic o_osc_in_pulldown,
    output logic o_aux_port_bit_one,
    output logic o_use_ext_clk
);
    clk_cfg_type cfg_ff;
    clk_cfg_type nxt_cfg;
    clk_state_type state_ff;
    clk_state_type nxt_state;
    logic ext_mode_ff;
    logic nxt_ext_mode;
    logic tuned_ff;
    logic [7:0] rdata_ff;
    logic stall_ff;
    logic chip_clk_en_ff;
    logic int_osc_en_ff;
    logic ext_osc_en_ff;
    logic restart_ff;
    logic out_pin_ff;
    logic aux_ff;
    logic lsr_en_ff;
    logic cfg_hit;
    logic wr_ext_rise;
    logic osc_in_sync;
    logic stable_sync;
    logic low_supply_sync;
    logic traffic_sync;
    logic load;
    logic [CNT_W-1:0] load_count;
    logic cnt_busy;
    logic cnt_done;
    logic supply_trip;
    logic settle_arm_ff;

    function automatic logic [CNT_W-1:0] resume_cycles(input logic ext, input logic long_dly);
        if (!ext) begin
            resume_cycles = CNT_W'(`RESUME_INT_CYC);
        end else if (long_dly) begin
            resume_cycles = CNT_W'(RESUME_LONG_CYCLES);
        end else begin
            resume_cycles = CNT_W'(`RESUME_SHORT_CYC);
        end
    endfunction : resume_cycles

    // pin and analog-side levels cross into the system clock here
    pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async({i_osc_in_pin, i_ext_osc_stable, i_low_supply, i_usb_traffic}),
        .o_sync({osc_in_sync, stable_sync, low_supply_sync, traffic_sync})
    );

    delay_counter #(
        .WIDTH(CNT_W)
    ) u_delay (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_load(load),
        .i_count(load_count),
        .o_busy(cnt_busy),
        .o_done(cnt_done)
    );

    assign cfg_hit = i_io_wr && (i_io_addr == `CLK_CFG_ADDR);
    assign wr_ext_rise = cfg_hit && i_io_wdata[`CLK_CFG_EXT_EN_BIT] && !ext_mode_ff;
    assign supply_trip = low_supply_sync && !cfg_ff.lsr_disable && state_ff != ST_SUSPEND;

    // register write; watchdog clears only the stored enable, not the mode
    always_comb begin
        nxt_cfg = cfg_ff;
        if (cfg_hit) begin
            nxt_cfg = clk_cfg_type'(i_io_wdata);
        end
        // a low-supply trip is a reset of its own, so the register clears
        if (supply_trip) begin
            nxt_cfg = clk_cfg_type'(`CLK_CFG_RESET);
        end
        if (i_watchdog_reset) begin
            nxt_cfg.ext_enable = 1'b0;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_ext_mode = ext_mode_ff;
        load = 1'b0;
        load_count = '0;
        case (state_ff)
            ST_INT_RUN: begin
                if (supply_trip) begin
                    nxt_state = ST_SETTLE;
                    load = 1'b1;
                    load_count = CNT_W'(SUPPLY_SETTLE_CYCLES);
                end else if (i_suspend_req) begin
                    nxt_state = ST_SUSPEND;
                end else if (wr_ext_rise) begin
                    nxt_state = ST_SWITCH_STOP;
                end
            end
            ST_SWITCH_STOP: begin
                nxt_ext_mode = 1'b1;
                nxt_state = ST_EXT_WAIT;
            end
            ST_EXT_WAIT: begin
                if (stable_sync) begin
                    nxt_state = ST_RESUME_DELAY;
                    load = 1'b1;
                    load_count = resume_cycles(1'b1, cfg_ff.resume_long);
                end
            end
            ST_RESUME_DELAY: begin
                if (cnt_done || !cnt_busy && !load) begin
                    nxt_state = ext_mode_ff ? ST_EXT_RUN : ST_INT_RUN;
                end
            end
            ST_EXT_RUN: begin
                // a cleared enable is ignored here, only a supply trip or suspend leaves external mode
                if (supply_trip) begin
                    nxt_ext_mode = 1'b0;
                    nxt_state = ST_SETTLE;
                    load = 1'b1;
                    load_count = CNT_W'(SUPPLY_SETTLE_CYCLES);
                end else if (i_suspend_req) begin
                    nxt_state = ST_SUSPEND;
                end
            end
            ST_SUSPEND: begin
                if (i_wake) begin
                    nxt_ext_mode = cfg_ff.ext_enable;
                    if (cfg_ff.ext_enable) begin
                        nxt_state = ST_EXT_WAIT;
                    end else begin
                        nxt_state = ST_RESUME_DELAY;
                        load = 1'b1;
                        load_count = resume_cycles(1'b0, cfg_ff.resume_long);
                    end
                end
            end
            ST_SETTLE: begin
                if (settle_arm_ff) begin
                    // brownout entry bypasses this decode, so the count starts here
                    load = 1'b1;
                    load_count = CNT_W'(SUPPLY_SETTLE_CYCLES);
                end else if (cnt_done) begin
                    nxt_state = ST_INT_RUN;
                end
            end
            default: begin
                nxt_state = ST_INT_RUN;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_ff <= clk_cfg_type'(`CLK_CFG_RESET);
            state_ff <= ST_INT_RUN;
            ext_mode_ff <= 1'b0;
        end else if (i_brownout_reset) begin
            cfg_ff <= clk_cfg_type'(`CLK_CFG_RESET);
            state_ff <= ST_SETTLE;
            ext_mode_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            // watchdog keeps the active mode and adds no wait
            state_ff <= nxt_state;
            ext_mode_ff <= nxt_ext_mode;
        end
    end

    // marks the first settle cycle after a brownout so the counter gets loaded
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            settle_arm_ff <= 1'b0;
        end else begin
            settle_arm_ff <= i_brownout_reset;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tuned_ff <= 1'b0;
        end else if (!cfg_ff.tune_enable || ext_mode_ff) begin
            tuned_ff <= 1'b0;
        end else if (traffic_sync) begin
            tuned_ff <= 1'b1;
        end
    end

    logic run_next;
    logic asleep_next;
    logic nxt_stall;
    logic nxt_chip_clk_en;
    logic nxt_int_osc_en;
    logic nxt_ext_osc_en;
    logic nxt_restart;
    logic nxt_out_pin;
    logic nxt_aux;
    logic nxt_lsr_en;
    logic [7:0] nxt_rdata;

    assign run_next = nxt_state == ST_INT_RUN || nxt_state == ST_EXT_RUN;
    assign asleep_next = nxt_state == ST_SUSPEND;
    // a brownout overrides the decode: core held, internal clock on, external off
    assign nxt_stall = i_brownout_reset || !run_next;
    assign nxt_chip_clk_en = i_brownout_reset
        || (nxt_state != ST_SWITCH_STOP && nxt_state != ST_EXT_WAIT && !asleep_next);
    assign nxt_int_osc_en = i_brownout_reset || (!nxt_ext_mode && !asleep_next);
    assign nxt_ext_osc_en = !i_brownout_reset && nxt_ext_mode && !asleep_next;
    assign nxt_restart = !i_brownout_reset && state_ff == ST_SETTLE
        && nxt_state == ST_INT_RUN;
    // output pin follows the internal clock only when enabled in internal mode
    assign nxt_out_pin = ext_mode_ff ? 1'b0 : (cfg_ff.out_disable | i_int_clk_phase);
    assign nxt_aux = ext_mode_ff ? 1'b0 : osc_in_sync;
    assign nxt_lsr_en = !cfg_ff.lsr_disable && state_ff != ST_SUSPEND;
    assign nxt_rdata = (i_io_addr == `CLK_CFG_ADDR) ? cfg_ff : 8'h00;

    // clock and stall controls
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            stall_ff <= 1'b0;
            chip_clk_en_ff <= 1'b1;
            int_osc_en_ff <= 1'b1;
            ext_osc_en_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            stall_ff <= nxt_stall;
            chip_clk_en_ff <= nxt_chip_clk_en;
            int_osc_en_ff <= nxt_int_osc_en;
            ext_osc_en_ff <= nxt_ext_osc_en;
            restart_ff <= nxt_restart;
        end
    end

    // read data and pin-side levels
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 8'h00;
            out_pin_ff <= 1'b0;
            aux_ff <= 1'b0;
            lsr_en_ff <= 1'b1;
        end else begin
            rdata_ff <= nxt_rdata;
            out_pin_ff <= nxt_out_pin;
            aux_ff <= nxt_aux;
            lsr_en_ff <= nxt_lsr_en;
        end
    end

    assign o_io_rdata = rdata_ff;
    assign o_cpu_stall = stall_ff;
    assign o_chip_clk_en = chip_clk_en_ff;
    assign o_int_osc_en = int_osc_en_ff;
    assign o_ext_osc_en = ext_osc_en_ff;
    assign o_fetch_restart = restart_ff;
    assign o_fetch_addr = `FETCH_START_ADDR;
    assign o_low_supply_reset_en = lsr_en_ff;
    assign o_tune_active = tuned_ff;
    // the wake timer itself lives elsewhere; this only holds its period select
    assign o_wake_period = cfg_ff.wake_adjust;
    assign o_osc_out_pin = out_pin_ff;
    // pull-down only in internal mode; no interrupt path exists from this input
    assign o_osc_in_pulldown = !ext_mode_ff;
    assign o_aux_port_bit_one = aux_ff;
    assign o_use_ext_clk = ext_mode_ff;
endmodule : clock_source_config_ctrl

/* File: hw/clock_source_config_regs.svh */
// register offsets, field positions, reset values and timing counts for clock source control
`ifndef CLOCK_SOURCE_CONFIG_REGS_SVH
`define CLOCK_SOURCE_CONFIG_REGS_SVH

`define CLK_CFG_ADDR 8'hF8
`define CLK_CFG_RESET 8'h00
`define CLK_CFG_RESUME_BIT 7
`define CLK_CFG_WAKE_MSB 6
`define CLK_CFG_WAKE_LSB 4
`define CLK_CFG_LSR_DIS_BIT 3
`define CLK_CFG_TUNE_BIT 2
`define CLK_CFG_OUT_DIS_BIT 1
`define CLK_CFG_EXT_EN_BIT 0
`define FETCH_START_ADDR 16'h0000

`define SYS_CLK_MHZ 100
`define RESUME_LONG_US 4000
`define RESUME_SHORT_US 128
`define RESUME_INT_US 8
`define INT_OSC_START_US 1
`define RESUME_LONG_CYC (`RESUME_LONG_US * `SYS_CLK_MHZ)
`define RESUME_SHORT_CYC (`RESUME_SHORT_US * `SYS_CLK_MHZ)
`define RESUME_INT_CYC ((`RESUME_INT_US + `INT_OSC_START_US) * `SYS_CLK_MHZ)
`define SUPPLY_SETTLE_US 4000
`define SUPPLY_SETTLE_CYC (`SUPPLY_SETTLE_US * `SYS_CLK_MHZ)

`endif

/* File: hw/clock_source_config_pkg.sv */
// shared types for clock source control
package clock_source_config_pkg;
    typedef struct packed {
        logic resume_long;
        logic [2:0] wake_adjust;
        logic lsr_disable;
        logic tune_enable;
        logic out_disable;
        logic ext_enable;
    } clk_cfg_type;

    typedef enum {
        ST_INT_RUN,
        ST_SWITCH_STOP,
        ST_EXT_WAIT,
        ST_RESUME_DELAY,
        ST_EXT_RUN,
        ST_SUSPEND,
        ST_SETTLE
    } clk_state_type;
endpackage : clock_source_config_pkg

/* File: hw/pin_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule : pin_sync

/* File: hw/delay_counter.sv */
// loadable down-counter that holds a busy level until it reaches zero
`timescale 1ns/1ps
module delay_counter #(
    parameter int WIDTH = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_busy,
    output logic o_done
);
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;
    logic busy_ff;
    logic done_ff;
    logic at_one;

    assign at_one = (count_ff == WIDTH'(1));
    assign nxt_count = i_load ? i_count : (busy_ff ? count_ff - WIDTH'(1) : count_ff);

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            count_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            busy_ff <= i_load ? (i_count != '0) : (busy_ff && !at_one);
            done_ff <= !i_load && busy_ff && at_one;
        end
    end

    assign o_busy = busy_ff;
    assign o_done = done_ff;
endmodule : delay_counter

/* File: sim/clock_source_config_ctrl_props.sv */
// port assertions for clock source control
`timescale 1ns/1ps
module clock_source_config_ctrl_props #(
    parameter int RESUME_LONG_CYCLES = 50
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_brownout_reset,
    input wire logic i_watchdog_reset,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    input wire logic [7:0] o_io_rdata,
    input wire logic i_ext_osc_stable,
    input wire logic o_int_osc_en,
    input wire logic o_ext_osc_en,
    input wire logic o_cpu_stall,
    input wire logic o_fetch_restart,
    input wire logic [15:0] o_fetch_addr,
    input wire logic o_low_supply_reset_en,
    input wire logic [2:0] o_wake_period,
    input wire logic o_use_ext_clk
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire wr_cfg = i_io_wr && i_io_addr == 8'hF8 && !i_brownout_reset && !i_watchdog_reset;
    logic [7:0] wd_ff;
    logic [7:0] wd2_ff;
    logic [31:0] stall_cnt_ff;
    // counts from the raw stable edge, so it includes the synchroniser lag
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            stall_cnt_ff <= '0;
        end else if (!i_ext_osc_stable) begin
            stall_cnt_ff <= '0;
        end else if (o_cpu_stall) begin
            stall_cnt_ff <= stall_cnt_ff + 32'h1;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        wd_ff <= i_io_wdata;
        wd2_ff <= wd_ff;
    end
    a_wake_period_set: assert property (wr_cfg |=> o_wake_period == wd_ff[6:4])
        else $error("wake period differs from written field");
    a_lsr_follows_bit: assert property (wr_cfg ##1 !(i_io_wr || i_brownout_reset)
        |=> o_low_supply_reset_en != wd2_ff[3])
        else $error("low supply reset enable wrong");
    a_rdata_unmapped: assert property (i_io_addr != 8'hF8 |=> o_io_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reset_defaults: assert property ($fell(i_rst) |-> !o_cpu_stall && o_int_osc_en
        && !o_ext_osc_en && o_low_supply_reset_en)
        else $error("reset state wrong");
    a_write_halts_core: assert property (wr_cfg && i_io_wdata[0] && !o_use_ext_clk && !o_cpu_stall
        |-> ##[1:3] o_cpu_stall ##[0:3] (o_ext_osc_en && !o_int_osc_en))
        else $error("switch did not halt and swap oscillators");
    a_halted_at_stable: assert property ($rose(i_ext_osc_stable) |-> o_cpu_stall)
        else $error("core ran before external oscillator stable");
    a_resume_delay_min: assert property ($fell(o_cpu_stall) && o_ext_osc_en
        |-> stall_cnt_ff >= RESUME_LONG_CYCLES)
        else $error("resume delay too short");
    a_keep_external: assert property (wr_cfg && !i_io_wdata[0] && o_use_ext_clk
        |=> o_use_ext_clk)
        else $error("clearing enable left external mode");
    a_fetch_from_zero: assert property (o_fetch_restart |-> o_fetch_addr == 16'h0000
        && o_int_osc_en && !o_use_ext_clk && !o_cpu_stall)
        else $error("restart address not zero");
    a_watchdog_keeps: assert property (i_watchdog_reset && !i_brownout_reset
        |=> $stable(o_use_ext_clk) && !o_cpu_stall)
        else $error("watchdog changed clock mode");
endmodule : clock_source_config_ctrl_props

bind clock_source_config_ctrl clock_source_config_ctrl_props #(
    .RESUME_LONG_CYCLES(RESUME_LONG_CYCLES)
) props (.*);

/* File: sim/ext_osc_model.sv */
// behavioural external resonator: reports stable after a start-up count
`timescale 1ns/1ps
module ext_osc_model (
    input wire logic i_sys_clk,
    input wire logic i_en,
    input wire logic [7:0] i_start_cycles,
    output logic o_stable
);
    logic [7:0] cnt_ff;
    always_ff @(posedge i_sys_clk) begin
        if (!i_en) begin
            cnt_ff <= 8'h00;
            o_stable <= 1'b0;
        end else if (cnt_ff >= i_start_cycles) begin
            o_stable <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule : ext_osc_model

/* File: sim/tb_clock_source_config_ctrl.sv */
// self-checking bench for clock source control
`timescale 1ns/1ps
module tb_clock_source_config_ctrl;
    logic clk, rst, bor, watchdog_reset, lowv, wr, susp, wake, osc_in, usb, phase, slow, rd_v, rd_seen;
    logic [7:0] addr, wdata, rdata, d;
    logic stable, int_en, ext_en, clk_en, stall, restart, lsr_en, tune, out_pin, pd, aux, use_ext;
    logic [15:0] fetch;
    logic [2:0] wperiod;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    int error_cnt, cmp_count, n;

    clock_source_config_ctrl #(.RESUME_LONG_CYCLES(50), .SUPPLY_SETTLE_CYCLES(40)) dut (
        .i_sys_clk(clk), .i_rst(rst), .i_brownout_reset(bor), .i_watchdog_reset(watchdog_reset),
        .i_low_supply(lowv), .i_io_wr(wr), .i_io_addr(addr), .i_io_wdata(wdata),
        .o_io_rdata(rdata), .i_suspend_req(susp), .i_wake(wake), .i_ext_osc_stable(stable),
        .i_osc_in_pin(osc_in), .i_usb_traffic(usb), .i_int_clk_phase(phase),
        .o_int_osc_en(int_en), .o_ext_osc_en(ext_en), .o_chip_clk_en(clk_en),
        .o_cpu_stall(stall), .o_fetch_restart(restart), .o_fetch_addr(fetch),
        .o_low_supply_reset_en(lsr_en), .o_tune_active(tune), .o_wake_period(wperiod),
        .o_osc_out_pin(out_pin), .o_osc_in_pulldown(pd), .o_aux_port_bit_one(aux),
        .o_use_ext_clk(use_ext));
    ext_osc_model osc (.i_sys_clk(clk), .i_en(ext_en),
        .i_start_cycles(slow ? 8'h3C : 8'h05), .o_stable(stable));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) phase <= #1 ~phase;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_cfg(input logic [7:0] v);
        wr = 1'b1;
        addr = 8'hF8;
        wdata = v;
        tick(1);
        wr = 1'b0;
    endtask : wr_cfg
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        exp_q.push_back(e);
        rd_v = 1'b1;
        tick(1);
        rd_v = 0;
        addr = 8'hF8;
        tick(1);
    endtask : rd
    task automatic wait_for(input string nm, ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            tick(1);
            n++;
        end
        chk(nm, v, s);
    endtask : wait_for
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    // read data is settled by the falling edge after the address edge
    always @(posedge clk) rd_seen <= rd_v;
    always @(negedge clk) if (rd_seen === 1'b1) chk("rdata", exp_q.pop_front(), rdata);

    initial begin
        #400000;
        error_cnt++;
        final_report;
    end

    initial begin
        {rst, bor, watchdog_reset, lowv, wr, susp, wake, osc_in, usb, phase, slow, rd_v} = 12'h800;
        addr = 8'hF8;
        wdata = 8'h00;
        seed = 32'hF3F7CEC7;
        tick(8);
        rst = 1'b0;
        rd(8'hF8, 8'h00);
        chk("int_osc_en", 1, int_en);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            d = seed[7:0] & 8'hFE;
            wr_cfg(d);
            tick(2);
            rd(8'hF8, d);
            chk("wake_period", d[6:4], wperiod);
            chk("lsr_en", !d[3], lsr_en);
        end
        rd(8'h55, 8'h00);
        wr_cfg(8'h02);
        tick(3);
        chk("out_pin_high", 1, out_pin);
        wr_cfg(8'h04);
        usb = 1'b1;
        osc_in = 1'b1;
        tick(4);
        d[0] = out_pin;
        tick(1);
        chk("out_pin_clock", !d[0], out_pin);
        chk("tune", 1, tune);
        chk("aux", 1, aux);
        chk("pulldown", 1, pd);
        usb = 1'b0;
        $display("register test done");
        lowv = 1'b1;
        tick(4);
        lowv = 1'b0;
        wait_for("fetch_restart", restart, 1, 200);
        tick(3);
        rd(8'hF8, 8'h00);
        $display("low supply test done");
        wr_cfg(8'h01);
        wait_for("halt", stall, 1, 5);
        wait_for("stable", stable, 1, 50);
        wait_for("release", stall, 0, 13000);
        chk("short_delay", 1, n >= 12800 && n <= 12810);
        chk("use_ext", 1, use_ext);
        watchdog_reset = 1'b1;
        tick(1);
        watchdog_reset = 1'b0;
        tick(2);
        rd(8'hF8, 8'h00);
        chk("mode_kept", 1, use_ext);
        wr_cfg(8'h80);
        tick(2);
        chk("no_return", 1, use_ext);
        $display("external switch test done");
        susp = 1'b1;
        tick(1);
        susp = 1'b0;
        tick(5);
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        wait_for("int_wake", stall, 0, 1200);
        chk("int_wake_time", 1, n >= 800 && n <= 1000);
        chk("back_internal", 0, use_ext);
        slow = 1'b1;
        wr_cfg(8'h81);
        wait_for("halt_long", stall, 1, 5);
        wait_for("stable_slow", stable, 1, 100);
        wait_for("release_long", stall, 0, 100);
        chk("long_delay", 1, n >= 50 && n <= 58);
        bor = 1'b1;
        tick(1);
        bor = 1'b0;
        wait_for("settle", stall, 0, 100);
        rd(8'hF8, 8'h00);
        chk("bor_internal", 0, use_ext);
        $display("wake and brownout test done");
        final_report;
    end
endmodule : tb_clock_source_config_ctrl
